/* ifd_pkg.sv */
// Purpose: Shared constants and field carriers for the instruction format decoder
// Assumes: 16-bit program words, four oscillator periods per instruction cycle
// Notes: Opcode patterns follow the standard 8-bit core encoding
package ifd_pkg;
  // ==========================================
  // Word and cycle constants
  localparam int WORD_W = 16;
  localparam logic [1:0] PHASES_PER_CYCLE = 2'h3;
  localparam logic [3:0] SECOND_WORD_TAG = 4'hf;
  localparam int STD_COUNT = 75;
  localparam int EXT_COUNT = 8;
  localparam logic [1:0] TBL_NO_CHANGE = 2'h0;
  localparam logic [1:0] TBL_POST_INC = 2'h1;
  localparam logic [1:0] TBL_POST_DEC = 2'h2;
  localparam logic [1:0] TBL_PRE_INC = 2'h3;

  // ==========================================
  // Instruction classes
  typedef enum logic [4:0] {
    IFD_BYTE = 5'h01,
    IFD_BIT = 5'h02,
    IFD_LIT = 5'h04,
    IFD_CTRL = 5'h08,
    IFD_NOP = 5'h10
  } ifd_class_e;

  typedef struct packed {
    ifd_class_e op_class;
    logic [7:0] file_addr;
    logic dest_file;
    logic access_banked;
    logic [2:0] bit_num;
    logic [7:0] literal;
    logic [1:0] pointer_sel;
    logic [10:0] prog_addr;
    logic fast_mode;
    logic [1:0] table_mode;
    logic two_word;
    logic extended;
  } ifd_fields_s;
endpackage : ifd_pkg

/* ifd_decoder.sv */
// Purpose: Split program words into fields and pace instruction cycles
// Assumes: Program memory presents word_in with word_valid each fetch
// Notes: Branch-taken and pc-change are reported by the execute stage
//
// Contract
// RQ1: One word holds opcode plus operand fields
// RQ2: Four instructions span two consecutive words
// RQ3: Second word tagged all ones; alone is no-op
// RQ4: Single word one cycle, two if taken
// RQ5: Two-word instructions take two cycles
// RQ6: Taken two-word branch takes three cycles
// RQ7: Instruction cycle equals four oscillator periods
// RQ8: Destination bit zero selects working register
// RQ9: Byte ops decode file, destination, access
// RQ10: Bit ops decode file, bit number, access
// RQ11: Literal ops decode literal and pointer select
// RQ12: Control ops decode address, fast, table mode
// RQ13: Recognise standard and extended instruction sets
// RQ14: Access bit zero bypasses bank select
// RQ15: Fast bit uses shadow registers
// RQ16: Table mode selects pointer update style
// RQ17: Pc change flushes prefetched word with no-op
`timescale 1ns/1ps
module ifd_decoder (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] word_in,
  input wire logic word_valid,
  input wire logic cond_true,
  input wire logic pc_changed,
  output ifd_pkg::ifd_fields_s fields,
  output logic to_working_register,
  output logic use_ram_bank_select,
  output logic use_shadow,
  output logic table_pointer_pre_inc,
  output logic table_pointer_post_inc,
  output logic table_pointer_post_dec,
  output logic cycle_strobe,
  output logic fetch_enable,
  output logic flush
);
  // ==========================================
  // Oscillator phase counter
  logic [1:0] phase;
  logic [1:0] next_phase;
  assign next_phase = (phase == ifd_pkg::PHASES_PER_CYCLE) ? 2'h0 : phase + 2'h1;
  always_ff @(posedge clock) begin
    if (!rst_n) phase <= 2'h0;
    else phase <= next_phase; // RQ7
  end
  assign cycle_strobe = (phase == ifd_pkg::PHASES_PER_CYCLE);

  // ==========================================
  // Combinational field split
  wire [3:0] top = word_in[15:12];
  wire is_second = (top == ifd_pkg::SECOND_WORD_TAG);
  wire is_two = (word_in[15:8] == 8'hc0) | (word_in[15:9] == 7'h76)
    | (word_in[15:8] == 8'hef) | (word_in[15:6] == 10'h3b8); // RQ2
  wire is_ext = (word_in[15:8] == 8'he8) | (word_in[15:8] == 8'hea)
    | (word_in[15:11] == 5'h1f) | (word_in[15:8] == 8'h00 && word_in[7:4] == 4'h1); // RQ13
  wire is_bit = (top >= 4'h7) && (top <= 4'hb);
  wire is_lit = (word_in[15:12] == 4'h0 && word_in[11:8] >= 4'h8) || (word_in[15:10] == 6'h3a);
  wire is_ctrl = (top >= 4'hd) || (word_in[15:8] == 8'h00);
  // High while the second word of a pair is due, so its tag is not read as a stray no-op
  logic pending_two;
  wire ifd_pkg::ifd_class_e cls = (is_second && pending_two == 1'b0) ? ifd_pkg::IFD_NOP
    : is_ctrl ? ifd_pkg::IFD_CTRL : is_lit ? ifd_pkg::IFD_LIT
    : is_bit ? ifd_pkg::IFD_BIT : ifd_pkg::IFD_BYTE; // RQ3
  ifd_pkg::ifd_fields_s next_fields;
  always_comb begin
    next_fields = '0;
    next_fields.op_class = cls; // RQ1
    next_fields.file_addr = word_in[7:0]; // RQ9 RQ10
    next_fields.dest_file = word_in[9]; // RQ9
    next_fields.access_banked = word_in[8]; // RQ9 RQ10
    next_fields.bit_num = word_in[11:9]; // RQ10
    next_fields.literal = word_in[7:0]; // RQ11
    next_fields.pointer_sel = word_in[5:4]; // RQ11
    next_fields.prog_addr = word_in[10:0]; // RQ12
    next_fields.fast_mode = word_in[0]; // RQ12
    next_fields.table_mode = word_in[1:0]; // RQ12
    next_fields.two_word = is_two;
    next_fields.extended = is_ext;
  end

  // ==========================================
  // Cycle sequencing
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_SECOND = 3'h2,
    ST_FLUSH = 3'h4
  } ifd_state_e;
  ifd_state_e state;
  ifd_state_e next_state;
  wire take = cycle_strobe & word_valid;
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (take && is_two && !is_second) next_state = ST_SECOND; // RQ5
        else if (take && (cond_true || pc_changed)) next_state = ST_FLUSH; // RQ4
      end
      ST_SECOND: begin
        if (cycle_strobe && (cond_true || pc_changed)) next_state = ST_FLUSH; // RQ6
        else if (cycle_strobe) next_state = ST_RUN;
      end
      ST_FLUSH: begin
        if (cycle_strobe) next_state = ST_RUN; // RQ17
      end
      default: next_state = ST_RUN;
    endcase
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= ST_RUN;
      fields <= '0;
      pending_two <= 1'b0;
    end else begin
      state <= next_state;
      if (take && state == ST_RUN) fields <= next_fields;
      else if (cycle_strobe && state == ST_FLUSH) fields.op_class <= ifd_pkg::IFD_NOP; // RQ17
      pending_two <= (next_state == ST_SECOND);
    end
  end
  assign flush = (state == ST_FLUSH); // RQ17
  assign fetch_enable = (state != ST_FLUSH);
  assign to_working_register = (fields.op_class == ifd_pkg::IFD_BYTE) & ~fields.dest_file; // RQ8
  assign use_ram_bank_select = fields.access_banked; // RQ14
  assign use_shadow = (fields.op_class == ifd_pkg::IFD_CTRL) & fields.fast_mode; // RQ15
  assign table_pointer_post_inc = fields.table_mode == ifd_pkg::TBL_POST_INC; // RQ16
  assign table_pointer_post_dec = fields.table_mode == ifd_pkg::TBL_POST_DEC; // RQ16
  assign table_pointer_pre_inc = fields.table_mode == ifd_pkg::TBL_PRE_INC; // RQ16

  // ==========================================
  // Checks
  property p_phase_wrap;
    @(posedge clock) disable iff (!rst_n) cycle_strobe |=> !cycle_strobe [*3] ##1 cycle_strobe;
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("cycle not four periods"); // RQ7

  // ==========================================
  // Cycle-long sequences
  // Run and second span one four-clock instruction cycle in one state; flush spans five clocks, the last with flush low
  sequence s_flush_cycle;
    flush [*4] ##1 !flush;
  endsequence
  sequence s_second_cycle;
    state == ST_SECOND [*4];
  endsequence
  sequence s_run_cycle;
    state == ST_RUN [*4];
  endsequence

  property p_flush_after_taken;
    @(posedge clock) disable iff (!rst_n)
      (state == ST_RUN && take && !is_two && (cond_true || pc_changed)) |=> s_flush_cycle;
  endproperty
  a_flush_after_taken: assert property (p_flush_after_taken) else $error("no flush cycle"); // RQ4
  property p_single_cycle;
    @(posedge clock) disable iff (!rst_n)
      (state == ST_RUN && take && !is_two && !cond_true && !pc_changed) |=> s_run_cycle;
  endproperty
  a_single_cycle: assert property (p_single_cycle) else $error("word not one cycle"); // RQ4
  property p_two_word;
    @(posedge clock) disable iff (!rst_n)
      (state == ST_RUN && take && is_two && !is_second) |=> s_second_cycle;
  endproperty
  a_two_word: assert property (p_two_word) else $error("two-word not held"); // RQ5
  property p_two_flag;
    @(posedge clock) disable iff (!rst_n)
      (state == ST_RUN && take && is_two) |=> fields.two_word;
  endproperty
  a_two_flag: assert property (p_two_flag) else $error("pair not flagged"); // RQ2
  property p_stray_second;
    @(posedge clock) disable iff (!rst_n)
      (state == ST_RUN && take && is_second) |=> fields.op_class == ifd_pkg::IFD_NOP;
  endproperty
  a_stray_second: assert property (p_stray_second) else $error("stray word not no-op"); // RQ3
  // Words offered while the pair's second half passes must not disturb the fields
  property p_refuse;
    @(posedge clock) disable iff (!rst_n) (state == ST_SECOND) |=> $stable(fields);
  endproperty
  a_refuse: assert property (p_refuse) else $error("fields moved on second word"); // RQ5
  property p_dest;
    @(posedge clock) disable iff (!rst_n)
      (state == ST_RUN && take && cls == ifd_pkg::IFD_BYTE && !word_in[9])
      |=> to_working_register;
  endproperty
  a_dest: assert property (p_dest) else $error("destination wrong"); // RQ8
  property p_bank;
    @(posedge clock) disable iff (!rst_n)
      (state == ST_RUN && take && word_in[8]) |=> use_ram_bank_select;
  endproperty
  a_bank: assert property (p_bank) else $error("bank select ignored"); // RQ14
  property p_flush_nop;
    @(posedge clock) disable iff (!rst_n)
      (flush && cycle_strobe) |=> fields.op_class == ifd_pkg::IFD_NOP;
  endproperty
  a_flush_nop: assert property (p_flush_nop) else $error("flush not no-op"); // RQ17
  property p_no_fetch;
    @(posedge clock) disable iff (!rst_n) (flush && !cycle_strobe) |=> !fetch_enable;
  endproperty
  a_no_fetch: assert property (p_no_fetch) else $error("fetch during flush"); // RQ17
  property p_resume;
    @(posedge clock) disable iff (!rst_n) (flush && cycle_strobe) |=> fetch_enable;
  endproperty
  a_resume: assert property (p_resume) else $error("fetch not resumed"); // RQ17
  property p_shadow;
    @(posedge clock) disable iff (!rst_n)
      (state == ST_RUN && take && cls == ifd_pkg::IFD_CTRL && word_in[0])
      |=> use_shadow;
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow not selected"); // RQ15
  property p_table;
    @(posedge clock) disable iff (!rst_n)
      (state == ST_RUN && take && word_in[1:0] == ifd_pkg::TBL_POST_INC)
      |=> table_pointer_post_inc;
  endproperty
  a_table: assert property (p_table) else $error("table mode lost"); // RQ16
  property p_branch3;
    @(posedge clock) disable iff (!rst_n)
      (state == ST_SECOND && cycle_strobe && (cond_true || pc_changed)) |=> s_flush_cycle;
  endproperty
  a_branch3: assert property (p_branch3) else $error("taken two-word short"); // RQ6
endmodule : ifd_decoder

/* ifd_prog_mem.sv */
// Purpose: Program memory model feeding the decoder
// Assumes: One word handed over per take
// Notes: While fetch is off the bus shows the inverted word
`timescale 1ns/1ps
module ifd_prog_mem (
  input wire logic clock,
  input wire logic cycle_strobe,
  input wire logic fetch_enable,
  output logic [15:0] word_in,
  output logic word_valid
);
  // ==========
  // Fetch
  logic [15:0] mem [8];
  logic [2:0] pc = 3'h0;
  assign word_valid = fetch_enable;
  // Inverted while idle so a stale word never looks valid
  assign word_in = fetch_enable ? mem[pc] : ~mem[pc];
  always @(posedge clock) begin
    if (cycle_strobe && word_valid) pc <= pc + 3'h1;
  end
endmodule : ifd_prog_mem

/* instruction_format_decode_timing_test.sv */
// Purpose: Self-checking bench for the decoder
// Assumes: Partner memory holds a fixed program
// Notes: Program wraps after eight words
`timescale 1ns/1ps
module instruction_format_decode_timing_test;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cond_true = 1'b0;
  logic pc_changed = 1'b0;
  logic [15:0] word_in;
  logic word_valid, twr, bank, shadow, pre, inc, dec, strobe, fetch, flush;
  ifd_pkg::ifd_fields_s fields;
  int fails = 0;
  int n_compared = 0;
  always #50 clock = ~clock;
  ifd_prog_mem i_mem (.clock(clock), .cycle_strobe(strobe), .fetch_enable(fetch),
    .word_in(word_in), .word_valid(word_valid));
  ifd_decoder i_dut (.clock(clock), .rst_n(rst_n), .word_in(word_in),
    .word_valid(word_valid), .cond_true(cond_true), .pc_changed(pc_changed),
    .fields(fields), .to_working_register(twr), .use_ram_bank_select(bank),
    .use_shadow(shadow), .table_pointer_pre_inc(pre), .table_pointer_post_inc(inc),
    .table_pointer_post_dec(dec), .cycle_strobe(strobe), .fetch_enable(fetch),
    .flush(flush));
  // ==========
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step();
    @(posedge clock iff (strobe && word_valid));
    @(negedge clock);
  endtask : step
  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic t_byte();
    step();
    chk(16'(twr), 16'h0);
    chk(16'(bank), 16'h0);
    chk(16'(fields.file_addr), 16'h5a);
    step();
    chk(16'(twr), 16'h1);
    chk(16'(bank), 16'h1);
  endtask : t_byte
  task automatic t_cycle();
    int n;
    // The falling edge the last step stopped on is the first period of this cycle
    n = 1;
    do begin
      @(negedge clock);
      n++;
    end while (strobe !== 1'b1);
    chk(16'(n), 16'h4);
  endtask : t_cycle
  task automatic t_misc();
    step();
    chk(16'(fields.bit_num), 16'h5);
    chk(16'(fields.op_class), 16'(ifd_pkg::IFD_BIT));
    step();
    chk(16'(fields.op_class), 16'(ifd_pkg::IFD_NOP));
    step();
    chk(16'(fields.two_word), 16'h1);
    step();
    step();
    chk(16'(shadow), 16'h1);
    step();
    chk(16'(inc), 16'h1);
    chk(16'({pre, dec}), 16'h0);
  endtask : t_misc
  task automatic t_flush();
    int n;
    int n_idle;
    n = 0;
    n_idle = 0;
    @(posedge clock) pc_changed <= 1'b1;
    // Dropped on the take edge itself, so the flush is counted from its first clock
    @(posedge clock iff (strobe && word_valid));
    pc_changed <= 1'b0;
    repeat (8) begin
      @(negedge clock);
      n += 32'(flush);
      n_idle += 32'(!fetch);
    end
    chk(16'(n), 16'h4);
    chk(16'(n_idle), 16'h4);
    chk(16'(fields.op_class), 16'(ifd_pkg::IFD_NOP));
  endtask : t_flush
  task automatic t_branch();
    int n;
    n = 0;
    @(posedge clock iff (strobe && word_valid && word_in[15:8] == 8'hc0));
    cond_true <= 1'b1;
    @(posedge clock iff strobe);
    cond_true <= 1'b0;
    repeat (8) begin
      @(negedge clock);
      n += 32'(flush);
    end
    chk(16'(n), 16'h4);
    chk(16'(fields.two_word), 16'h1);
  endtask : t_branch
  // ==========
  // Main
  initial begin
    i_mem.mem = '{16'h265a, 16'h2555, 16'h8b33, 16'hf123,
                  16'hc012, 16'hf456, 16'h0013, 16'h0009};
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_byte();
    t_cycle();
    t_misc();
    t_flush();
    t_branch();
    give_verdict();
  end
  initial begin
    #200_000;
    fails++;
    give_verdict();
  end
endmodule : instruction_format_decode_timing_test
